// ==== logic/stmc_pkg.sv ====
package stmc_pkg;
    // register indices; byte address is index times four
    localparam logic [11:0] PERIOD_IDX = 12'h480;
    localparam logic [11:0] RUNCTL_IDX = 12'h481;
    localparam logic [11:0] THRESH_IDX = 12'h482;
    localparam logic [11:0] STATUS_IDX = 12'h483;
    localparam logic [13:0] PERIOD_ADDR = {PERIOD_IDX, 2'b00};
    localparam logic [13:0] RUNCTL_ADDR = {RUNCTL_IDX, 2'b00};
    localparam logic [13:0] THRESH_ADDR = {THRESH_IDX, 2'b00};
    localparam logic [13:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
    // field positions
    localparam int START_BIT = 0;
    localparam int PERIODIC_BIT = 1;
    localparam int UV_LSB = 12;
    localparam int OV_LSB = 8;
    localparam int OT_LSB = 0;
    // reset values
    localparam logic [3:0] PERIOD_RST = 4'h2;
    localparam logic [13:0] RUNCTL_RSVD_RST = 14'h0028;
    localparam logic PERIODIC_RST = 1'b1;
    localparam logic [2:0] UV_RST = 3'h7;
    localparam logic [2:0] OV_RST = 3'h0;
    localparam logic [2:0] OT_RST = 3'h7;
    // timing: one period unit is 16 ms at 20 MHz
    localparam int CLK_HZ = 20000000;
    localparam int UNIT_MS = 16;
    localparam int UNIT_CYC = CLK_HZ / 1000 * UNIT_MS;
    localparam int RUN_CYC = 4;
    // sensor result bundle
    typedef struct packed {
        logic [2:0] temp;
        logic [2:0] vio;
        logic [2:0] vana;
    } stmc_meas_s;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_WAIT = 2'b10
    } stmc_state_e;
endpackage : stmc_pkg

// ==== logic/stmc_top.sv ====
`timescale 1ns/1ps
// Contract
// - periodic bit set repeats monitor runs; clear gives single run
// - periodic interval comes from 4-bit period register field
// - writing one to start launches run; self-clears; zero ignored
// - voltage codes 000..111 run from above +9% to below -16.5%
// - undervoltage threshold bits 14:12, resets to 111
// - overvoltage threshold bits 10:8, resets to 000
// - overtemperature threshold bits 2:0, resets 111; 000 below -40C
// - cycle time is code times 16 ms; resets 0010; 0000 invalid
module stmc_top #(
    parameter int UNIT_CYCLES = stmc_pkg::UNIT_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [13:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // sensor side
    output logic sense_en,
    input wire stmc_pkg::stmc_meas_s meas_in,
    // status
    output logic alarm,
    output logic busy
);
    // software visible state
    logic [3:0] period_reg;
    logic [13:0] rsvd_reg;
    logic periodic_reg;
    logic start_reg;
    logic [15:0] thresh_reg;
    // sequencer state and timers
    stmc_pkg::stmc_state_e state_reg;
    logic [31:0] timer_reg;
    logic [3:0] unit_reg;
    // threshold flags and synced sensor codes
    logic [2:0] alarm_bits_reg;
    stmc_pkg::stmc_meas_s meas_s1_reg;
    stmc_pkg::stmc_meas_s meas_s2_reg;
    // decoded fields and strobes
    logic [2:0] uv_thr;
    logic [2:0] ov_thr;
    logic [2:0] ot_thr;
    logic wr_run;
    logic wr_period;
    logic wr_thresh;
    logic run_end;
    logic [1:0] vio_cross;
    logic [1:0] vana_cross;

    // write strobe aimed at one register
    function automatic logic wr_hit(
        input logic wr,
        input logic [13:0] addr,
        input logic [13:0] target
    );
        return wr && addr == target;
    endfunction : wr_hit

    // supply code against limits; lower code is higher voltage
    // band edges scale with the nominal supply on the analog side, so
    // only the codes are compared here; result is {under, over}
    function automatic logic [1:0] band_cross(
        input logic [2:0] code,
        input logic [2:0] ov,
        input logic [2:0] uv
    );
        return {code > uv, code < ov};
    endfunction : band_cross

    // field views of the threshold register
    assign uv_thr = thresh_reg[stmc_pkg::UV_LSB +: 3];
    assign ov_thr = thresh_reg[stmc_pkg::OV_LSB +: 3];
    assign ot_thr = thresh_reg[stmc_pkg::OT_LSB +: 3];
    // register write decode
    assign wr_run = wr_hit(reg_wr, reg_addr, stmc_pkg::RUNCTL_ADDR);
    assign wr_period = wr_hit(reg_wr, reg_addr, stmc_pkg::PERIOD_ADDR);
    assign wr_thresh = wr_hit(reg_wr, reg_addr, stmc_pkg::THRESH_ADDR);
    // last cycle of a run
    assign run_end = state_reg == stmc_pkg::ST_RUN &&
        timer_reg == 32'(stmc_pkg::RUN_CYC - 1);
    // per supply crossing flags
    assign vio_cross = band_cross(meas_s2_reg.vio, ov_thr, uv_thr);
    assign vana_cross = band_cross(meas_s2_reg.vana, ov_thr, uv_thr);

    // sensor codes cross from analog side
    always_ff @(posedge mclk) begin
        meas_s1_reg <= meas_in;
        meas_s2_reg <= meas_s1_reg;
    end

    // period register
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            period_reg <= stmc_pkg::PERIOD_RST;
        end else if (wr_period) begin
            period_reg <= reg_wdata[3:0];
        end
    end

    // run control register
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rsvd_reg <= stmc_pkg::RUNCTL_RSVD_RST;
            periodic_reg <= stmc_pkg::PERIODIC_RST;
        end else if (wr_run) begin
            rsvd_reg <= reg_wdata[15:2];
            periodic_reg <= reg_wdata[stmc_pkg::PERIODIC_BIT];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            start_reg <= 1'b0;
        end else if (wr_run && reg_wdata[stmc_pkg::START_BIT]) begin
            start_reg <= 1'b1;
        end else if (state_reg == stmc_pkg::ST_IDLE) begin
            start_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            thresh_reg <= {1'b0, stmc_pkg::UV_RST, 1'b0, stmc_pkg::OV_RST,
                5'h00, stmc_pkg::OT_RST};
        end else if (wr_thresh) begin
            thresh_reg <= reg_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_reg <= stmc_pkg::ST_IDLE;
            timer_reg <= 32'h0;
            unit_reg <= 4'h0;
        end else begin
            case (state_reg)
                stmc_pkg::ST_IDLE: begin
                    if (start_reg) begin
                        state_reg <= stmc_pkg::ST_RUN;
                        timer_reg <= 32'h0;
                    end
                end
                stmc_pkg::ST_RUN: begin
                    if (timer_reg == 32'(stmc_pkg::RUN_CYC - 1)) begin
                        timer_reg <= 32'h0;
                        unit_reg <= 4'h0;
                        state_reg <= periodic_reg ? stmc_pkg::ST_WAIT
                                                  : stmc_pkg::ST_IDLE;
                    end else begin
                        timer_reg <= timer_reg + 32'h1;
                    end
                end
                stmc_pkg::ST_WAIT: begin
                    if (!periodic_reg) begin
                        state_reg <= stmc_pkg::ST_IDLE;
                    end else if (timer_reg == 32'(UNIT_CYCLES - 1)) begin
                        timer_reg <= 32'h0;
                        if (unit_reg + 4'h1 >= period_reg) begin
                            state_reg <= stmc_pkg::ST_RUN;
                        end else begin
                            unit_reg <= unit_reg + 4'h1;
                        end
                    end else begin
                        timer_reg <= timer_reg + 32'h1;
                    end
                end
                default: state_reg <= stmc_pkg::ST_IDLE;
            endcase
        end
    end

    // compare at end of run; lower code is higher voltage
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            alarm_bits_reg <= 3'h0;
        end else if (run_end) begin
            alarm_bits_reg[0] <= meas_s2_reg.temp > ot_thr;
            alarm_bits_reg[1] <= vio_cross[0] || vana_cross[0];
            alarm_bits_reg[2] <= vio_cross[1] || vana_cross[1];
        end
    end

    // outputs from flops
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sense_en <= 1'b0;
            busy <= 1'b0;
            alarm <= 1'b0;
        end else begin
            sense_en <= state_reg == stmc_pkg::ST_RUN;
            busy <= state_reg != stmc_pkg::ST_IDLE;
            alarm <= |alarm_bits_reg;
        end
    end

    // read data one cycle after strobe
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                stmc_pkg::PERIOD_ADDR: reg_rdata <= {12'h000, period_reg};
                stmc_pkg::RUNCTL_ADDR:
                    reg_rdata <= {rsvd_reg, periodic_reg, start_reg};
                stmc_pkg::THRESH_ADDR: reg_rdata <= thresh_reg;
                stmc_pkg::STATUS_ADDR:
                    reg_rdata <= {12'h000, busy, alarm_bits_reg};
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end
endmodule : stmc_top

// ==== bench/stmc_top_sva.sv ====
`timescale 1ns/1ps
module stmc_chk #(
    parameter int UNIT_CYCLES = 10
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [13:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // monitor side
    input wire logic sense_en,
    input wire stmc_pkg::stmc_meas_s meas_in,
    input wire logic alarm,
    input wire logic busy
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic rc_w, go_w, zero_w, map_w;
    logic [2:0] go_q;
    // decoded run-control writes and mapped reads
    assign rc_w = reg_wr && reg_addr == stmc_pkg::RUNCTL_ADDR;
    assign go_w = rc_w && reg_wdata[0];
    assign zero_w = rc_w && !reg_wdata[0];
    assign map_w = reg_addr[13:4] == 10'h120 && reg_addr[1:0] == 2'h0;
    // recent launch writes, so a pending start is not mistaken
    always_ff @(posedge mclk) begin
        if (!rst_b) go_q <= '0;
        else go_q <= {go_q[1:0], go_w};
    end
    // one run: four active cycles then off
    sequence s_run;
        sense_en [*4] ##1 !sense_en;
    endsequence
    a_start_launch: assert property (go_w && !busy |-> ##[2:4] sense_en)
        else $error("start write did not launch a run");
    a_run_len: assert property ($rose(sense_en) |-> s_run)
        else $error("run length wrong");
    a_busy_run: assert property (sense_en |-> busy)
        else $error("run active while not busy");
    a_zero_ignored: assert property (zero_w && !busy && go_q == 3'h0
        |=> !sense_en [*3])
        else $error("zero start launched a run");
    a_wait_min: assert property ($fell(sense_en) && busy
        |-> !sense_en [*8])
        else $error("periodic rerun too soon");
    a_rd_unmapped: assert property (reg_rd && !map_w |=> reg_rdata == 16'h0)
        else $error("unmapped read not zero");
    a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b
        |=> !sense_en && !busy && !alarm && reg_rdata == 16'h0)
        else $error("outputs not cleared by reset");
endmodule : stmc_chk
bind stmc_top stmc_chk #(.UNIT_CYCLES(UNIT_CYCLES)) u_chk (.mclk, .rst_b,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sense_en,
    .meas_in, .alarm, .busy);

// ==== bench/tb_stmc_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
    mismatches++; $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_stmc_top;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [13:0] reg_addr = '0;
    logic [15:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata, thr, d;
    logic sense_en, alarm, busy, sen_q;
    logic [2:0] fl;
    stmc_pkg::stmc_meas_s meas_in = '0;
    logic [31:0] seed = 32'h34;
    int mismatches = 0;
    int n_compared = 0;
    int runs, p, t;
    stmc_top #(.UNIT_CYCLES(10)) uut (.mclk, .rst_b, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .sense_en, .meas_in, .alarm, .busy);
    // clock and run counter
    initial forever #25 mclk = ~mclk;
    always @(posedge mclk) begin
        if (sense_en === 1'b1 && sen_q !== 1'b1) runs++;
        sen_q <= sense_en;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic wr(input logic [13:0] a, input logic [15:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic ck(input string n, logic [13:0] a, logic [15:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 `CHK(n, e, reg_rdata)
    endtask : ck
    task automatic wait_idle();
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge mclk);
    endtask : wait_idle
    task automatic results();
        if (mismatches == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        results();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        ck("period", stmc_pkg::PERIOD_ADDR, 16'h0002);
        ck("runctl", stmc_pkg::RUNCTL_ADDR, 16'h00a2);
        ck("thresh", stmc_pkg::THRESH_ADDR, 16'h7007);
        ck("unmapped", 14'h0000, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            thr = 16'(xs());
            wr(stmc_pkg::THRESH_ADDR, thr);
            ck("thresh", stmc_pkg::THRESH_ADDR, thr);
            @(posedge mclk);
            meas_in <= 9'(xs());
            runs = 0;
            wr(stmc_pkg::RUNCTL_ADDR, 16'h00a1);
            wait_idle();
            repeat (20) @(posedge mclk);
            fl[0] = meas_in.temp > thr[2:0];
            fl[1] = meas_in.vio < thr[10:8] || meas_in.vana < thr[10:8];
            fl[2] = meas_in.vio > thr[14:12] || meas_in.vana > thr[14:12];
            `CHK("runs", 1, runs)
            `CHK("alarm", |fl, alarm)
            ck("status", stmc_pkg::STATUS_ADDR, {13'h0000, fl});
            ck("runctl", stmc_pkg::RUNCTL_ADDR, 16'h00a0);
        end
        runs = 0;
        wr(stmc_pkg::RUNCTL_ADDR, 16'h00a0);
        repeat (10) @(posedge mclk);
        `CHK("zero start", 0, runs)
        p = 1 + xs() % 3;
        d = 16'(xs());
        d[3:0] = 4'(p);
        wr(stmc_pkg::PERIOD_ADDR, d);
        ck("period", stmc_pkg::PERIOD_ADDR, 16'(p));
        runs = 0;
        wr(stmc_pkg::RUNCTL_ADDR, 16'h00a3);
        for (t = 0; t < 400 && runs < 2; t++) @(posedge mclk);
        `CHK("periodic runs", 2, runs)
        `CHK("spacing", 1'b1, t >= 4 + 10 * p)
        wr(stmc_pkg::RUNCTL_ADDR, 16'h00a0);
        wait_idle();
        results();
    end
endmodule : tb_stmc_top
